// File: hdl/hcsm_regs.sv
/*
  Register bank: descriptor-area fill flags, asynchronous done timeout,
  per-bank auto-incrementing PIO read pointer and edge interrupt shaping.
  Assumes the processor interface logic decodes its pins into one-cycle
  read/write strobes on clock_in, and that scheduler events are synchronous.
*/
`timescale 1ns/10ps

// Notes on behaviour
// [R01] Isochronous area flag bit 2 enables processing of that area, zero skips it.
// [R02] Periodic area flag bit 1 enables processing of that area, zero skips it.
// [R03] Asynchronous area flag bit 0 enables processing of that area, zero skips it.
// [R04] A 32-bit millisecond timeout, reset zero, raises the interrupt when enabled.
// [R05] Only completed asynchronous descriptors start the timeout.
// [R06] A written read start address is latched as the pointer of the chosen bank.
// [R07] Each memory read of a bank advances its pointer until a new address is written.
// [R08] Software writes the start address and bank only before a read series.
// [R09] Bits 17 to 16 select one of four memory banks.
// [R10] Bank selection steers only PIO memory accesses, never DMA.
// [R11] Bits 15 to 0 hold the 16-bit start address of a contiguous read series.
// [R12] The start address serves PIO memory reads only.
// [R13] Software writes reserved bits with their reset value.
// [R14] An 8-bit gap in 125 us units spaces edge interrupts; zero means no spacing.
// [R15] A 16-bit count sets how many clocks an edge interrupt pulse lasts.
// [R16] A set area flag makes the scheduler walk that area's valid, unskipped headers.
// [R17] A zero timeout value disables the timeout interrupt.
module hcsm_regs
  import hcsm_pkg::*;
#(
  parameter int MS_CYCLES = HCSM_MS_CYC,
  parameter int UFRAME_CYCLES = HCSM_UFRAME_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Register strobes
  input wire hcsm_bus_req_t bus_req_in,
  output logic [31:0] bus_rdata_out,
  // PIO memory read port
  input wire logic mem_rd_in,
  output logic [1:0] mem_bank_out,
  output logic [15:0] mem_addr_out,
  // Scheduler side
  output hcsm_area_flags_t area_flags_out,
  input wire logic async_done_in,
  // Interrupt line
  input wire logic tmo_irq_enable_in,
  input wire logic other_irq_in,
  input wire logic irq_level_mode_in,
  input wire logic irq_ack_in,
  output logic irq_out
);

  // ==========================================================
  // Register decode
  logic wr_area, wr_tmo, wr_mem, wr_edge;
  assign wr_area = bus_req_in.wr && (bus_req_in.addr == HCSM_OFS_AREA);
  assign wr_tmo = bus_req_in.wr && (bus_req_in.addr == HCSM_OFS_TMO);
  assign wr_mem = bus_req_in.wr && (bus_req_in.addr == HCSM_OFS_MEM);
  assign wr_edge = bus_req_in.wr && (bus_req_in.addr == HCSM_OFS_EDGE);

  // ==========================================================
  // Storage registers
  logic [2:0] area_r, area_nxt;
  logic [31:0] tmo_r, tmo_nxt;
  logic [31:0] edge_r, edge_nxt;
  logic [1:0] bank_r, bank_nxt;
  logic [15:0] ptr_r [HCSM_NUM_BANKS];
  logic [15:0] ptr_nxt [HCSM_NUM_BANKS];
  logic [31:0] rdata_r, rdata_nxt;

  // Next values; a pointer write in the same cycle as a read wins
  always_comb begin
    area_nxt = area_r;
    tmo_nxt = tmo_r;
    edge_nxt = edge_r;
    bank_nxt = bank_r;
    ptr_nxt = ptr_r;
    if (wr_area) begin
      area_nxt = bus_req_in.wdata[HCSM_ISO_BIT:HCSM_ASYNC_BIT]; // R01 R02 R03
    end
    if (wr_tmo) begin
      tmo_nxt = bus_req_in.wdata; // R04
    end
    if (wr_edge) begin
      edge_nxt = bus_req_in.wdata;
    end
    if (mem_rd_in) begin
      ptr_nxt[bank_r] = ptr_r[bank_r] + 16'h0001; // R07 R11
    end
    if (wr_mem) begin
      bank_nxt = bus_req_in.wdata[HCSM_BANK_MSB:HCSM_BANK_LSB]; // R09
      ptr_nxt[bus_req_in.wdata[HCSM_BANK_MSB:HCSM_BANK_LSB]] =
        bus_req_in.wdata[HCSM_ADDR_MSB:0]; // R06
    end
    rdata_nxt = 32'h00000000;
    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        HCSM_OFS_AREA: rdata_nxt = {29'h00000000, area_r};
        HCSM_OFS_TMO: rdata_nxt = tmo_r;
        HCSM_OFS_MEM: rdata_nxt = {14'h0000, bank_r, ptr_r[bank_r]};
        HCSM_OFS_EDGE: rdata_nxt = edge_r;
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      area_r <= HCSM_AREA_RST[2:0];
      tmo_r <= HCSM_TMO_RST;
      edge_r <= HCSM_EDGE_RST;
      bank_r <= HCSM_BANK_RST;
      for (int i = 0; i < HCSM_NUM_BANKS; i++) begin
        ptr_r[i] <= HCSM_PTR_RST;
      end
      rdata_r <= 32'h00000000;
    end else begin
      area_r <= area_nxt;
      tmo_r <= tmo_nxt;
      edge_r <= edge_nxt;
      bank_r <= bank_nxt;
      ptr_r <= ptr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Scheduler flags straight from storage; the walk itself lives in the scheduler
  assign area_flags_out = '{iso: area_r[HCSM_ISO_BIT], periodic: area_r[HCSM_PER_BIT],
                            async_list: area_r[HCSM_ASYNC_BIT]}; // R01 R02 R03 R16
  assign bus_rdata_out = rdata_r;
  // Bank only reaches the PIO path, DMA has its own address
  assign mem_bank_out = bank_r; // R10
  assign mem_addr_out = ptr_r[bank_r]; // R12

  // ==========================================================
  // Asynchronous done timeout
  logic tmo_run_r, tmo_run_nxt;
  logic [31:0] ms_left_r, ms_left_nxt;
  logic [31:0] tick_r, tick_nxt;
  // Run length and loaded count, kept only for the timing check
  logic [31:0] tmo_age_r, tmo_age_nxt;
  logic [31:0] tmo_load_r, tmo_load_nxt;
  logic tmo_fire;
  logic ms_wrap;

  assign ms_wrap = (tick_r == 32'(MS_CYCLES - 1));
  assign tmo_fire = tmo_run_r && ms_wrap && (ms_left_r == 32'h00000001); // R04

  // One timer per batch: later dones while it runs do not restart it
  always_comb begin
    tmo_run_nxt = tmo_run_r;
    ms_left_nxt = ms_left_r;
    tick_nxt = tick_r;
    tmo_age_nxt = tmo_run_r ? tmo_age_r + 32'h00000001 : 32'h00000000;
    tmo_load_nxt = tmo_run_r ? tmo_load_r : tmo_r;
    if (tmo_run_r) begin
      tick_nxt = ms_wrap ? 32'h00000000 : tick_r + 32'h00000001;
      if (ms_wrap) begin
        ms_left_nxt = ms_left_r - 32'h00000001;
      end
      if (tmo_fire) begin
        tmo_run_nxt = 1'b0;
      end
    end else if (async_done_in && (tmo_r != 32'h00000000)) begin // R05 R17
      tmo_run_nxt = 1'b1;
      ms_left_nxt = tmo_r;
      tick_nxt = 32'h00000000;
    end
    if (wr_tmo && (bus_req_in.wdata == 32'h00000000)) begin
      tmo_run_nxt = 1'b0; // R17
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tmo_run_r <= 1'b0;
      ms_left_r <= 32'h00000000;
      tick_r <= 32'h00000000;
      tmo_age_r <= 32'h00000000;
      tmo_load_r <= 32'h00000000;
    end else begin
      tmo_run_r <= tmo_run_nxt;
      ms_left_r <= ms_left_nxt;
      tick_r <= tick_nxt;
      tmo_age_r <= tmo_age_nxt;
      tmo_load_r <= tmo_load_nxt;
    end
  end

  // ==========================================================
  // Interrupt shaping
  hcsm_irq_state_t st_r, st_nxt;
  logic pend_r, pend_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic irq_r, irq_nxt;
  logic evt;
  logic [15:0] pulse_clks;
  logic [7:0] gap_uf;

  assign evt = (tmo_fire && tmo_irq_enable_in) || other_irq_in; // R04
  assign pulse_clks = edge_r[HCSM_CLKS_MSB:0];
  assign gap_uf = edge_r[HCSM_GAP_MSB:HCSM_GAP_LSB];

  // Pending event: a new event beats a clear in the same cycle
  always_comb begin
    pend_nxt = pend_r;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    if (irq_level_mode_in && irq_ack_in) begin
      pend_nxt = 1'b0;
    end
    case (st_r)
      HCSM_IRQ_IDLE: begin
        if (!irq_level_mode_in && pend_r) begin
          pend_nxt = 1'b0;
          st_nxt = HCSM_IRQ_PULSE;
          // Zero width would swallow the event, so one clock is the floor
          cnt_nxt = (pulse_clks == 16'h0000) ? 32'h00000001 : {16'h0000, pulse_clks}; // R15
        end
      end
      HCSM_IRQ_PULSE: begin
        cnt_nxt = cnt_r - 32'h00000001;
        if (cnt_r == 32'h00000001) begin
          st_nxt = (gap_uf == 8'h00) ? HCSM_IRQ_IDLE : HCSM_IRQ_GAP; // R14
          cnt_nxt = 32'(gap_uf) * 32'(UFRAME_CYCLES);
        end
      end
      HCSM_IRQ_GAP: begin
        cnt_nxt = cnt_r - 32'h00000001;
        if (cnt_r == 32'h00000001) begin
          st_nxt = HCSM_IRQ_IDLE; // R14
        end
      end
      default: begin
        st_nxt = HCSM_IRQ_IDLE;
      end
    endcase
    if (evt) begin
      pend_nxt = 1'b1;
    end
    irq_nxt = irq_level_mode_in ? pend_nxt : (st_nxt == HCSM_IRQ_PULSE); // R15
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_r <= HCSM_IRQ_IDLE;
      pend_r <= 1'b0;
      cnt_r <= 32'h00000000;
      irq_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pend_r <= pend_nxt;
      cnt_r <= cnt_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign irq_out = irq_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  a_iso_area_flag: assert property (wr_area |=> // R01
    area_flags_out.iso == $past(bus_req_in.wdata[HCSM_ISO_BIT]))
    else $error("iso flag not taken from write");
  a_per_area_flag: assert property (wr_area |=> // R02
    area_flags_out.periodic == $past(bus_req_in.wdata[HCSM_PER_BIT]))
    else $error("periodic flag not taken from write");
  a_async_area_flag: assert property (wr_area |=> // R03
    area_flags_out.async_list == $past(bus_req_in.wdata[HCSM_ASYNC_BIT]))
    else $error("async flag not taken from write");
  a_tmo_fire_cause: assert property (tmo_fire |-> // R04
    tmo_age_r + 32'h00000001 == 32'(tmo_load_r * 32'(MS_CYCLES)))
    else $error("timeout fired at the wrong time");
  a_tmo_async_only: assert property ($rose(tmo_run_r) |-> $past(async_done_in)) // R05
    else $error("timer started without async done");
  a_zero_tmo_quiet: assert property (tmo_r == 32'h00000000 |-> !tmo_fire) // R17
    else $error("timeout fired while disabled");
  a_ptr_latch: assert property (wr_mem |=> // R06
    mem_addr_out == $past(bus_req_in.wdata[HCSM_ADDR_MSB:0]) &&
    mem_bank_out == $past(bus_req_in.wdata[HCSM_BANK_MSB:HCSM_BANK_LSB]))
    else $error("pointer not latched");
  a_ptr_advance: assert property (mem_rd_in && !wr_mem |=> // R07
    mem_addr_out == $past(mem_addr_out) + 16'h0001)
    else $error("pointer did not advance");
  sequence s_pulse_start;
    !irq_level_mode_in && st_r == HCSM_IRQ_IDLE && pend_r ##1 1'b1;
  endsequence
  a_edge_pulse_high: assert property (s_pulse_start |-> irq_out) // R15
    else $error("edge pulse missing");
  a_edge_gap_low: assert property (st_r == HCSM_IRQ_GAP && !irq_level_mode_in |-> !irq_out) // R14
    else $error("irq asserted inside gap");
endmodule

// File: inc/hcsm_pkg.sv
/*
  Constants and types for the schedule, memory-pointer and interrupt register bank.
  Assumes one 50 MHz core clock and a register strobe interface from the same clock domain.
*/
package hcsm_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] HCSM_OFS_AREA = 12'h334;
  localparam logic [11:0] HCSM_OFS_TMO = 12'h338;
  localparam logic [11:0] HCSM_OFS_MEM = 12'h33C;
  localparam logic [11:0] HCSM_OFS_EDGE = 12'h340;

  // ==========================================================
  // Field positions
  localparam int HCSM_ISO_BIT = 2;
  localparam int HCSM_PER_BIT = 1;
  localparam int HCSM_ASYNC_BIT = 0;
  localparam int HCSM_BANK_LSB = 16;
  localparam int HCSM_BANK_MSB = 17;
  localparam int HCSM_ADDR_MSB = 15;
  localparam int HCSM_GAP_LSB = 24;
  localparam int HCSM_GAP_MSB = 31;
  localparam int HCSM_CLKS_MSB = 15;
  localparam int HCSM_NUM_BANKS = 4;

  // ==========================================================
  // Reset values
  localparam logic [31:0] HCSM_AREA_RST = 32'h00000000;
  localparam logic [31:0] HCSM_TMO_RST = 32'h00000000;
  localparam logic [15:0] HCSM_PTR_RST = 16'h0000;
  localparam logic [1:0] HCSM_BANK_RST = 2'h0;
  localparam logic [31:0] HCSM_EDGE_RST = 32'h0000000F;

  // ==========================================================
  // Timing: one millisecond and one microframe in core clocks
  localparam int HCSM_CLK_PERIOD_NS = 20;
  localparam int HCSM_MS_NS = 1000000;
  localparam int HCSM_UFRAME_NS = 125000;
  localparam int HCSM_MS_CYC = HCSM_MS_NS / HCSM_CLK_PERIOD_NS;
  localparam int HCSM_UFRAME_CYC = HCSM_UFRAME_NS / HCSM_CLK_PERIOD_NS;

  // ==========================================================
  // Types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } hcsm_bus_req_t;

  typedef struct packed {
    logic iso;
    logic periodic;
    logic async_list;
  } hcsm_area_flags_t;

  typedef enum logic [1:0] {
    HCSM_IRQ_IDLE,
    HCSM_IRQ_PULSE,
    HCSM_IRQ_GAP
  } hcsm_irq_state_t;
endpackage

// File: tb/hcsm_cpu_model.sv
/*
  Processor model: issues register strobes and PIO memory read pulses.
  Assumes the bank samples all requests on the rising edge of clock_in.
*/
`timescale 1ns/10ps

module hcsm_cpu_model
  import hcsm_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Requests towards the bank
  output hcsm_bus_req_t bus_req_out,
  output logic mem_rd_out
);
  // ==========================================================
  // Idle at time zero
  initial begin
    bus_req_out = '0;
    mem_rd_out = 1'b0;
  end

  // One strobe cycle, then inverted address and data so stale values never match
  task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clock_in);
    #1;
    bus_req_out = '{wr: wr, rd: !wr, addr: addr, wdata: data};
    @(posedge clock_in);
    #1;
    bus_req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  // Pointer is programmed by the caller first; reads then rely on increment
  task automatic mem_read();
    @(posedge clock_in);
    #1;
    mem_rd_out = 1'b1;
    @(posedge clock_in);
    #1;
    mem_rd_out = 1'b0;
  endtask
endmodule

// File: tb/hcsm_regs_tb_top.sv
/*
  Self-checking bench for the register bank, driven through the processor model.
  Assumes short counts: 4 clocks per millisecond, 3 clocks per microframe.
*/
`timescale 1ns/10ps

module hcsm_regs_tb_top
  import hcsm_pkg::*;
  ;
  logic clock_in, sys_rst_in, mem_rd, done, tmo_en, oth, lvl, ack, irq;
  hcsm_bus_req_t bus_req;
  hcsm_area_flags_t flags;
  logic [31:0] rdata;
  logic [1:0] bank;
  logic [15:0] maddr, a, pat;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int n_tests = 0;
  integer seed = 32'h44d3;

  hcsm_cpu_model u_cpu (.clock_in(clock_in), .bus_req_out(bus_req), .mem_rd_out(mem_rd));
  hcsm_regs #(.MS_CYCLES(4), .UFRAME_CYCLES(3)) u_dut (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .bus_req_in(bus_req), .bus_rdata_out(rdata),
    .mem_rd_in(mem_rd), .mem_bank_out(bank), .mem_addr_out(maddr),
    .area_flags_out(flags), .async_done_in(done), .tmo_irq_enable_in(tmo_en),
    .other_irq_in(oth), .irq_level_mode_in(lvl), .irq_ack_in(ack), .irq_out(irq));

  // ==========================================================
  // Clock, helpers
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic rd(input logic [11:0] addr, input logic [31:0] exp);
    exp_q.push_back(exp);
    u_cpu.access(1'b0, addr, 32'h00000000);
  endtask

  task automatic pulse_done();
    done = 1'b1;
    tick(1);
    done = 1'b0;
  endtask

  // Edge run: one event, a second two clocks into the pulse, 16 samples of the line
  task automatic edge_run(input logic [31:0] cfg, input logic [15:0] exp);
    u_cpu.access(1'b1, HCSM_OFS_EDGE, cfg);
    rd(HCSM_OFS_EDGE, cfg);
    oth = 1'b1;
    tick(1);
    oth = 1'b0;
    pat = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      tick(1);
      pat = {pat[14:0], irq};
      oth = (i == 1);
    end
    chk(32'(pat), 32'(exp));
  endtask

  // Read data stands just after the taking edge; oldest note is compared
  always @(posedge clock_in) begin
    if (bus_req.rd === 1'b1) begin
      #1;
      chk(rdata, exp_q.pop_front());
    end
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog well above the under two hundred cycles the sequence needs
  initial begin
    #(3000 * 20);
    error_cnt++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {done, tmo_en, oth, lvl, ack} = 5'h00;
    sys_rst_in = 1'b1;
    repeat (6) @(posedge clock_in);
    #1;
    sys_rst_in = 1'b0;
    rd(HCSM_OFS_AREA, HCSM_AREA_RST);
    rd(HCSM_OFS_TMO, HCSM_TMO_RST);
    rd(HCSM_OFS_MEM, 32'h00000000);
    rd(HCSM_OFS_EDGE, HCSM_EDGE_RST);
    rd(12'h344, 32'h00000000);
    // Every flag combination, reserved bits kept at zero
    for (int v = 0; v < 8; v++) begin
      u_cpu.access(1'b1, HCSM_OFS_AREA, 32'(v));
      chk(32'(flags), 32'(v));
      rd(HCSM_OFS_AREA, 32'(v));
    end
    // Each bank latches and advances; last bank crosses the 16-bit wrap
    for (int b = 0; b < 4; b++) begin
      a = (b == 3) ? 16'hFFFE : 16'($random(seed));
      u_cpu.access(1'b1, HCSM_OFS_MEM, {14'h0000, 2'(b), a});
      chk(32'(bank), 32'(b));
      chk(32'(maddr), 32'(a));
      for (int n = 1; n <= 3; n++) begin
        u_cpu.mem_read();
        chk(32'(maddr), 32'(16'(a + 16'(n))));
      end
      rd(HCSM_OFS_MEM, {14'h0000, 2'(b), 16'(a + 16'h0003)});
    end
    // Level mode: timeout of 2 ms fires 8 clocks after the done
    lvl = 1'b1;
    tmo_en = 1'b1;
    u_cpu.access(1'b1, HCSM_OFS_TMO, 32'h00000002);
    pulse_done();
    tick(7);
    chk(32'(irq), 32'h00000000);
    tick(1);
    chk(32'(irq), 32'h00000001);
    ack = 1'b1;
    tick(1);
    ack = 1'b0;
    chk(32'(irq), 32'h00000000);
    // Zero write cancels a running timer, later dones stay silent
    u_cpu.access(1'b1, HCSM_OFS_TMO, 32'h00000002);
    pulse_done();
    tick(3);
    u_cpu.access(1'b1, HCSM_OFS_TMO, 32'h00000000);
    pulse_done();
    tick(20);
    chk(32'(irq), 32'h00000000);
    u_cpu.access(1'b1, HCSM_OFS_TMO, 32'h00000001);
    tmo_en = 1'b0;
    pulse_done();
    tick(10);
    chk(32'(irq), 32'h00000000);
    // Edge mode: 3-clock pulses, gap of one microframe plus the idle clock before
    // the held event restarts; then zero width (one clock) with no gap
    lvl = 1'b0;
    edge_run(32'h01000003, 16'hE1C0);
    edge_run(32'h00000000, 16'h9000);
    final_report();
  end
endmodule
